/* hw/bus_defines.svh */
`ifndef BUS_DEFINES_SVH
`define BUS_DEFINES_SVH

`define BUS_CMD_UNPROT_SETUP   8'h60
`define BUS_CMD_CONFIRM        8'hD0
`define BUS_CMD_READ_ARRAY     8'hFF
`define BUS_CMD_CLEAR_STATUS   8'h50
`define BUS_CMD_READ_STATUS    8'h70

`define BUS_SR_READY_BIT       7
`define BUS_SR_ERASE_ERR_BIT   5
`define BUS_SR_PROG_ERR_BIT    4
`define BUS_SR_ENABLE_ERR_BIT  3

`define BUS_UNPROT_CYCLES      16'h0010

`define BUS_REG_CTRL           32'h0000_0000
`define BUS_REG_STATUS         32'h0000_0004
`define BUS_REG_IRQ_STATUS     32'h0000_0008
`define BUS_REG_IRQ_MASK       32'h0000_000C
`define BUS_REG_READ_DATA      32'h0000_0010

`define BUS_CTRL_START_BIT     0
`define BUS_CTRL_ADDR_LSB      8

`define BUS_RES_OK             3'h0
`define BUS_RES_ENABLE_ERR     3'h1
`define BUS_RES_SEQ_ERR        3'h2
`define BUS_RES_UNPROT_ERR     3'h3

`define BUS_IRQ_DONE_BIT       0
`define BUS_IRQ_ERR_BIT        1

`endif

/* hw/bus_pkg.sv */
package bus_pkg;
   typedef enum logic [4:0] {
      BUS_DEV_ARRAY  = 5'b0_0001,
      BUS_DEV_STATUS = 5'b0_0010,
      BUS_DEV_SETUP  = 5'b0_0100,
      BUS_DEV_BUSY   = 5'b0_1000,
      BUS_DEV_OTHER  = 5'b1_0000
   } bus_dev_state_t;

   typedef enum logic [7:0] {
      BUS_HST_IDLE   = 8'b0000_0001,
      BUS_HST_SETUP  = 8'b0000_0010,
      BUS_HST_CONF   = 8'b0000_0100,
      BUS_HST_POLL   = 8'b0000_1000,
      BUS_HST_WAIT   = 8'b0001_0000,
      BUS_HST_EVAL   = 8'b0010_0000,
      BUS_HST_FINISH = 8'b0100_0000,
      BUS_HST_READ   = 8'b1000_0000
   } bus_hst_state_t;
endpackage : bus_pkg

/* hw/bus_link_if.sv */
interface bus_link_if;
   logic        wr_stb;
   logic        rd_stb;
   logic [4:0]  addr;
   logic [7:0]  wdata;
   logic [15:0] rdata;

   modport device (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
   modport host   (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
endinterface : bus_link_if

/* hw/bus_flash_dev.sv */
`include "bus_defines.svh"

module bus_flash_dev #(
   parameter logic [15:0] UNPROT_CYCLES = `BUS_UNPROT_CYCLES
) (
   input  wire logic   clock,
   input  wire logic   rst_n,
   bus_link_if.device  link,
   input  wire logic   program_erase_enable_input,
   input  wire logic   unprotect_fail,
   input  wire logic [15:0] array_data,
   output logic [4:0]  protect_clear_addr,
   output logic        protect_clear_stb
);
   typedef struct packed {
      bus_pkg::bus_dev_state_t st;
      logic [15:0] cnt;
      logic        rdy;
      logic        e_err;
      logic        p_err;
      logic        v_err;
      logic        vbad;
      logic [4:0]  blk;
      logic [15:0] rdata;
      logic [4:0]  pc_addr;
      logic        pc_stb;
   } bus_dev_s_t;

   bus_dev_s_t s_r, s_nxt;

   function automatic logic [7:0] status_byte(input bus_dev_s_t s);
      status_byte = 8'h00;
      status_byte[`BUS_SR_READY_BIT]      = s.rdy;
      status_byte[`BUS_SR_ERASE_ERR_BIT]  = s.e_err;
      status_byte[`BUS_SR_PROG_ERR_BIT]   = s.p_err;
      status_byte[`BUS_SR_ENABLE_ERR_BIT] = s.v_err;
   endfunction : status_byte

   always_comb begin
      s_nxt = s_r;
      s_nxt.pc_stb = 1'b0;
      if (s_r.st == bus_pkg::BUS_DEV_BUSY) begin
         if (!program_erase_enable_input)
            s_nxt.vbad = 1'b1;
         if (s_r.cnt == 16'h0000) begin
            s_nxt.rdy = 1'b1;
            s_nxt.st  = bus_pkg::BUS_DEV_STATUS;
            if (s_r.vbad || !program_erase_enable_input)
               s_nxt.v_err = 1'b1;
            else if (unprotect_fail)
               s_nxt.e_err = 1'b1;
            else begin
               s_nxt.pc_stb  = 1'b1;
               s_nxt.pc_addr = s_r.blk;
            end
         end else
            s_nxt.cnt = s_r.cnt - 16'h0001;
      end else if (link.wr_stb) begin
         case (s_r.st)
            bus_pkg::BUS_DEV_SETUP: begin
               if (link.wdata == `BUS_CMD_CONFIRM) begin
                  s_nxt.st   = bus_pkg::BUS_DEV_BUSY;
                  s_nxt.rdy  = 1'b0;
                  s_nxt.cnt  = UNPROT_CYCLES;
                  s_nxt.vbad = 1'b0;
                  s_nxt.blk  = link.addr;
               end else begin
                  s_nxt.p_err = 1'b1;
                  s_nxt.e_err = 1'b1;
                  s_nxt.st    = bus_pkg::BUS_DEV_STATUS;
               end
            end
            default: begin
               case (link.wdata)
                  `BUS_CMD_UNPROT_SETUP: s_nxt.st = bus_pkg::BUS_DEV_SETUP;
                  `BUS_CMD_READ_ARRAY:   s_nxt.st = bus_pkg::BUS_DEV_ARRAY;
                  `BUS_CMD_READ_STATUS:  s_nxt.st = bus_pkg::BUS_DEV_STATUS;
                  `BUS_CMD_CLEAR_STATUS: begin
                     s_nxt.p_err = 1'b0;
                     s_nxt.e_err = 1'b0;
                     s_nxt.v_err = 1'b0;
                  end
                  `BUS_CMD_CONFIRM: begin
                     s_nxt.p_err = 1'b1;
                     s_nxt.e_err = 1'b1;
                     s_nxt.st    = bus_pkg::BUS_DEV_STATUS;
                  end
                  default: ;
               endcase
            end
         endcase
      end
      // Read word follows the mode being entered, so it is valid one cycle after a command
      if (s_nxt.st == bus_pkg::BUS_DEV_ARRAY)
         s_nxt.rdata = array_data;
      else
         s_nxt.rdata = {8'h00, status_byte(s_nxt)};
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_r       <= '0;
         s_r.st    <= bus_pkg::BUS_DEV_ARRAY;
         s_r.rdy   <= 1'b1;
      end else
         s_r <= s_nxt;
   end

   assign link.rdata         = s_r.rdata;
   assign protect_clear_addr = s_r.pc_addr;
   assign protect_clear_stb  = s_r.pc_stb;
endmodule : bus_flash_dev

/* hw/bus_unprot_host.sv */
// Function
// - Host writes 60h then D0h with block
// - Poll until ready; device holds ready low
// - Device flags enable invalid during operation
// - Bad sequence sets program and erase errors
// - Unprotect failure sets erase error alone
// - FFh returns device to array read
// - Clear status after error before next operation
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`include "bus_defines.svh"

module bus_unprot_host (
   input  wire logic          clock,
   input  wire logic          rst_n,
   bus_link_if.host           link,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic [31:0]        hrdata,
   output logic               hreadyout,
   output logic               hresp,
   output logic               irq
);
   typedef struct packed {
      bus_pkg::bus_hst_state_t st;
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [7:0]  wdata;
      logic [4:0]  blk;
      logic [2:0]  result;
      logic        err_seen;
      logic [15:0] rbuf;
      logic [1:0]  ists;
      logic [1:0]  imask;
      logic        irq;
      logic        ph_v;
      logic        ph_w;
      logic [31:0] ph_a;
      logic [31:0] hrdata;
   } bus_hst_s_t;

   bus_hst_s_t s_r, s_nxt;

   function automatic logic [31:0] reg_read(input bus_hst_s_t s, input logic [31:0] a);
      reg_read = 32'h0000_0000;
      case (a)
         `BUS_REG_CTRL:       reg_read = {19'h0_0000, s.blk, 8'h00};
         `BUS_REG_STATUS:     reg_read = {24'h00_0000, s.err_seen, s.result,
                                          3'h0, (s.st == bus_pkg::BUS_HST_IDLE)};
         `BUS_REG_IRQ_STATUS: reg_read = {30'h0000_0000, s.ists};
         `BUS_REG_IRQ_MASK:   reg_read = {30'h0000_0000, s.imask};
         `BUS_REG_READ_DATA:  reg_read = {16'h0000, s.rbuf};
         default:             reg_read = 32'h0000_0000;
      endcase
   endfunction : reg_read

   always_comb begin
      logic [1:0] iset;
      logic       start;
      logic [7:0] sr;
      iset  = 2'b00;
      start = 1'b0;
      sr    = link.rdata[7:0];
      s_nxt = s_r;
      s_nxt.wr = 1'b0;
      s_nxt.rd = 1'b0;
      s_nxt.ph_v = hsel && htrans[1] && hready;
      s_nxt.ph_w = hwrite;
      s_nxt.ph_a = haddr;
      if (s_nxt.ph_v && !hwrite)
         s_nxt.hrdata = reg_read(s_r, haddr);
      if (s_r.ph_v && s_r.ph_w) begin
         case (s_r.ph_a)
            `BUS_REG_CTRL: begin
               s_nxt.blk = hwdata[`BUS_CTRL_ADDR_LSB +: 5];
               start     = hwdata[`BUS_CTRL_START_BIT];
            end
            `BUS_REG_IRQ_STATUS: s_nxt.ists = s_r.ists & ~hwdata[1:0];
            `BUS_REG_IRQ_MASK:   s_nxt.imask = hwdata[1:0];
            default: ;
         endcase
      end
      case (s_r.st)
         bus_pkg::BUS_HST_IDLE: begin
            if (start) begin
               s_nxt.wr    = 1'b1;
               s_nxt.addr  = s_r.err_seen ? s_r.addr : hwdata[`BUS_CTRL_ADDR_LSB +: 5];
               s_nxt.wdata = s_r.err_seen ? `BUS_CMD_CLEAR_STATUS : `BUS_CMD_UNPROT_SETUP;
               s_nxt.err_seen = 1'b0;
               s_nxt.st    = bus_pkg::BUS_HST_SETUP;
            end
         end
         bus_pkg::BUS_HST_SETUP: begin
            s_nxt.wr    = 1'b1;
            s_nxt.addr  = s_r.blk;
            s_nxt.wdata = (s_r.wdata == `BUS_CMD_CLEAR_STATUS) ? `BUS_CMD_UNPROT_SETUP : `BUS_CMD_CONFIRM;
            if (s_r.wdata != `BUS_CMD_CLEAR_STATUS)
               s_nxt.st = bus_pkg::BUS_HST_CONF;
         end
         bus_pkg::BUS_HST_CONF: begin
            s_nxt.rd = 1'b1;
            s_nxt.st = bus_pkg::BUS_HST_POLL;
         end
         bus_pkg::BUS_HST_POLL: s_nxt.st = bus_pkg::BUS_HST_WAIT;
         bus_pkg::BUS_HST_WAIT: begin
            if (sr[`BUS_SR_READY_BIT])
               s_nxt.st = bus_pkg::BUS_HST_EVAL;
            else begin
               s_nxt.rd = 1'b1;
               s_nxt.st = bus_pkg::BUS_HST_POLL;
            end
         end
         bus_pkg::BUS_HST_EVAL: begin
            if (sr[`BUS_SR_ENABLE_ERR_BIT])
               s_nxt.result = `BUS_RES_ENABLE_ERR;
            else if (sr[`BUS_SR_PROG_ERR_BIT] && sr[`BUS_SR_ERASE_ERR_BIT])
               s_nxt.result = `BUS_RES_SEQ_ERR;
            else if (sr[`BUS_SR_ERASE_ERR_BIT])
               s_nxt.result = `BUS_RES_UNPROT_ERR;
            else
               s_nxt.result = `BUS_RES_OK;
            s_nxt.err_seen = |{sr[`BUS_SR_ENABLE_ERR_BIT], sr[`BUS_SR_PROG_ERR_BIT],
                               sr[`BUS_SR_ERASE_ERR_BIT]};
            s_nxt.wr    = 1'b1;
            s_nxt.wdata = `BUS_CMD_READ_ARRAY;
            s_nxt.st    = bus_pkg::BUS_HST_FINISH;
         end
         bus_pkg::BUS_HST_FINISH: begin
            s_nxt.rd = 1'b1;
            s_nxt.st = bus_pkg::BUS_HST_READ;
         end
         bus_pkg::BUS_HST_READ: begin
            s_nxt.st = bus_pkg::BUS_HST_IDLE;
            iset[`BUS_IRQ_DONE_BIT] = 1'b1;
            iset[`BUS_IRQ_ERR_BIT]  = s_r.err_seen;
         end
         default: s_nxt.st = bus_pkg::BUS_HST_IDLE;
      endcase
      if (s_r.st == bus_pkg::BUS_HST_READ)
         s_nxt.rbuf = link.rdata;
      s_nxt.ists = s_nxt.ists | iset;
      s_nxt.irq  = |(s_nxt.ists & s_nxt.imask);
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_r    <= '0;
         s_r.st <= bus_pkg::BUS_HST_IDLE;
      end else
         s_r <= s_nxt;
   end

   assign link.wr_stb = s_r.wr;
   assign link.rd_stb = s_r.rd;
   assign link.addr   = s_r.addr;
   assign link.wdata  = s_r.wdata;
   assign hrdata      = s_r.hrdata;
   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign irq         = s_r.irq;
endmodule : bus_unprot_host

/* verif/bus_link_sva.sv */
`include "bus_defines.svh"

module bus_link_sva (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        wr_stb,
   input wire logic        rd_stb,
   input wire logic [4:0]  addr,
   input wire logic [7:0]  wdata,
   input wire logic [15:0] rdata
);
   logic       stat_r;
   logic       err_r;
   logic       q1_r;
   logic       q2_r;
   logic [4:0] blk_r;
   logic       stat;

   // Status byte is trusted only from three cycles after the last command
   assign stat = stat_r && !wr_stb && !q1_r && !q2_r;

   always_ff @(posedge clock) begin
      q1_r <= wr_stb;
      q2_r <= q1_r;
      if (!rst_n) begin
         stat_r <= 1'b0;
         err_r  <= 1'b0;
         blk_r  <= 5'h0_0;
      end else begin
         if (wr_stb) begin
            stat_r <= wdata != `BUS_CMD_READ_ARRAY;
         end
         if (wr_stb && wdata == `BUS_CMD_UNPROT_SETUP) begin
            blk_r <= addr;
         end
         if (wr_stb && wdata == `BUS_CMD_CLEAR_STATUS) begin
            err_r <= 1'b0;
         end else if (stat && rdata[`BUS_SR_READY_BIT] && (rdata[3] || rdata[5])) begin
            err_r <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_setup;
      wr_stb && wdata == `BUS_CMD_UNPROT_SETUP;
   endsequence
   sequence s_conf;
      wr_stb && wdata == `BUS_CMD_CONFIRM;
   endsequence
   sequence s_ready;
      stat && rdata[`BUS_SR_READY_BIT];
   endsequence

   AST_SETUP_CONFIRM: assert property (s_setup |-> ##[1:20] s_conf) else $error("confirm missing");
   AST_SAME_BLOCK: assert property (s_conf |-> addr == blk_r) else $error("confirm block differs");
   AST_BUSY_LOW: assert property (s_conf |=> ##2 (!rdata[`BUS_SR_READY_BIT]) [*4]) else $error("ready early");
   AST_READY_BOUND: assert property (s_conf |-> ##[3:300] s_ready) else $error("never ready");
   AST_FINISH: assert property (s_conf ##1 first_match(##[0:300] s_ready)
      |-> ##[1:60] (wr_stb && wdata == `BUS_CMD_READ_ARRAY)) else $error("no read array");
   AST_CLEAR_FIRST: assert property (s_setup |-> !err_r) else $error("start with errors set");
   AST_ERR_HELD: assert property (err_r && stat |-> rdata[3] || rdata[5]) else $error("error flag lost");
   AST_NO_PROG_ERR: assert property (s_ready |-> !rdata[4]) else $error("program error flag");
endmodule : bus_link_sva

/* verif/tb_block_unprotect_sequencer.sv */
`include "bus_defines.svh"

module tb_block_unprotect_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, pe_en = 1'b1, ufail = 1'b0, rd_dp = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = '0, hwdata = '0, rv, hrdata;
   logic [15:0] arr = 16'h0000;
   logic        hreadyout, irq, pc_stb;
   logic [4:0]  pc_addr;
   int          fail_count = 0, n_tests = 0, seed = 60879;
   logic [31:0] exp_q[$], msk_q[$];
   logic [4:0]  addr_q[$];
   bus_link_if  link ();

   bus_flash_dev bus_flash_dev_inst (.clock(clock), .rst_n(rst_n), .link(link), .program_erase_enable_input(pe_en),
      .unprotect_fail(ufail), .array_data(arr), .protect_clear_addr(pc_addr), .protect_clear_stb(pc_stb));
   bus_unprot_host bus_unprot_host_inst (.clock(clock), .rst_n(rst_n), .link(link), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .irq(irq));
   bus_link_sva bus_link_sva_inst (.clock(clock), .rst_n(rst_n), .wr_stb(link.wr_stb), .rd_stb(link.rd_stb),
      .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata));

   always #12.5 clock = ~clock;

   task automatic complete_run();
      if (fail_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         fail_count++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check

   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, input logic c);
      @(posedge clock);
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsel   <= 1'b1;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      rd_dp  <= c;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rv = hrdata;
      rd_dp <= 1'b0;
   endtask : xfer

   // Queue the expectation, then issue the read that produces it
   task automatic exp_rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      xfer(a, 1'b0, 32'h0000_0000, 1'b1);
   endtask : exp_rd

   task automatic irq_chk(input logic [31:0] a, input logic [31:0] d, input logic want);
      xfer(a, 1'b1, d, 1'b0);
      repeat (2) @(posedge clock);
      check(32'(irq), 32'(want));
   endtask : irq_chk

   task automatic run_op(input logic [4:0] b, input logic e, input logic f, input logic [2:0] res);
      pe_en <= e;
      ufail <= f;
      arr   <= 16'($random(seed));
      if (res == `BUS_RES_OK) addr_q.push_back(b);
      xfer(`BUS_REG_CTRL, 1'b1, {19'h0_0000, b, 8'h01}, 1'b0);
      repeat (3) @(posedge clock);
      rv = '0;
      while (rv[0] !== 1'b1) xfer(`BUS_REG_STATUS, 1'b0, 32'h0000_0000, 1'b0);
      exp_rd(`BUS_REG_STATUS, {24'h00_0000, res != 3'h0, res, 4'h1}, 32'h0000_00F1);
      exp_rd(`BUS_REG_READ_DATA, {16'h0000, arr}, 32'hFFFF_FFFF);
      exp_rd(`BUS_REG_IRQ_STATUS, {30'h0000_0000, res != 3'h0, 1'b1}, 32'h0000_0003);
      irq_chk(`BUS_REG_IRQ_MASK, 32'h0000_0003, 1'b1);
      irq_chk(`BUS_REG_IRQ_STATUS, 32'h0000_0003, 1'b0);
      irq_chk(`BUS_REG_IRQ_MASK, 32'h0000_0000, 1'b0);
      exp_rd(`BUS_REG_IRQ_STATUS, 32'h0000_0000, 32'h0000_0003);
   endtask : run_op

   always @(posedge clock) begin
      if (rd_dp) check(hrdata & msk_q.pop_front(), exp_q.pop_front());
      if (pc_stb === 1'b1) check(32'(pc_addr), 32'(addr_q.pop_front()));
   end

   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      complete_run();
   end

   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      run_op(5'h00, 1'b1, 1'b0, `BUS_RES_OK);
      run_op(5'h1F, 1'b0, 1'b0, `BUS_RES_ENABLE_ERR);
      run_op(5'($random(seed)), 1'b1, 1'b1, `BUS_RES_UNPROT_ERR);
      run_op(5'($random(seed)), 1'b1, 1'b0, `BUS_RES_OK);
      exp_rd(32'h0000_0020, 32'h0000_0000, 32'hFFFF_FFFF);
      repeat (4) @(posedge clock);
      check(32'(addr_q.size()), 32'h0000_0000);
      complete_run();
   end
endmodule : tb_block_unprotect_sequencer
